// ---- bench/ctz_prog_mem.sv ----
// fetch stream and operand memory model facing the decoder
`timescale 1ns/1ps
module ctz_prog_mem (
  // clock
  input  wire logic        CLK,
  // instruction byte stream
  input  wire logic        FETCH_REQ,
  output logic [7:0]       FETCH_BYTE,
  // operand memory
  input  wire logic        MEM_RD,
  input  wire logic [15:0] MEM_ADDR,
  output logic [7:0]       MEM_RDATA,
  // bench control
  input  wire logic        start,
  input  wire logic [95:0] code,
  input  wire logic [7:0]  mdat,
  output logic [7:0]       ptr
);
  logic [95:0] prog_q = {12{8'h9D}};
  logic [7:0]  ptr_q  = 8'hF0;
  logic [7:0]  last_q = 8'h00;
  logic [7:0]  byte_c;

  always @(posedge CLK) begin
    if (start) begin
      prog_q <= code;
      ptr_q  <= 8'h00;
    end else if (FETCH_REQ && ptr_q != 8'hFF) begin
      ptr_q <= ptr_q + 8'h01;
    end
    if (MEM_RD) begin
      last_q <= mdat;
    end
  end

  // past the loaded bytes a foreign opcode keeps the decoder busy
  assign byte_c = (ptr_q < 8'h0C) ? prog_q[95 - 8*ptr_q -: 8] : 8'h9D;
  // unread lines show the inverse so a stale sample is caught
  assign FETCH_BYTE = FETCH_REQ ? byte_c : ~byte_c;
  assign MEM_RDATA  = MEM_RD ? mdat : ~last_q;
  assign ptr        = ptr_q;
endmodule

// ---- bench/tb_top.sv ----
// self-checking bench for the transfer, test and wait decoder
`timescale 1ns/1ps
module tb_top;
  logic               CLK = 1'b0;
  logic               RST_N = 1'b0;
  logic               FETCH_REQ, MEM_RD, EA_VALID, CORE_CLK_EN, FOREIGN;
  logic [7:0]         FETCH_BYTE, MEM_RDATA, REL_OFS, ptr;
  logic [15:0]        MEM_ADDR, EA, rd_addr;
  logic               EA_REQ = 1'b0, IRQ = 1'b0, start = 1'b0;
  ctz_pkg::ctz_mode_e EA_MODE = ctz_pkg::AM_IMPL;
  ctz_pkg::ctz_regs_s REGS;
  logic [95:0]        code = '0;
  logic [7:0]         mdat = 8'h00;
  int                 fail_count = 0, compares = 0, cycles = 0, eas = 0;
  int                 cyc, k;

  always #4 CLK = ~CLK;

  ctz_decoder u_dut (.CLK(CLK), .RST_N(RST_N), .FETCH_REQ(FETCH_REQ),
    .FETCH_BYTE(FETCH_BYTE), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
    .MEM_RDATA(MEM_RDATA), .EA_REQ(EA_REQ), .EA_MODE(EA_MODE),
    .EA_VALID(EA_VALID), .EA(EA), .REL_OFS(REL_OFS), .FOREIGN(FOREIGN),
    .IRQ(IRQ), .CORE_CLK_EN(CORE_CLK_EN), .REGS(REGS));
  ctz_prog_mem u_mem (.CLK(CLK), .FETCH_REQ(FETCH_REQ),
    .FETCH_BYTE(FETCH_BYTE), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
    .MEM_RDATA(MEM_RDATA), .start(start), .code(code), .mdat(mdat),
    .ptr(ptr));

  always @(posedge CLK) begin
    if (MEM_RD === 1'b1) begin
      rd_addr <= MEM_ADDR;
    end
    if (EA_VALID === 1'b1) begin
      eas <= eas + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // checks and access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // order a, x, h, sp, flags
  task automatic chk_regs(input logic [47:0] exp);
    compares++;
    if (REGS !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, REGS, exp);
    end
  endtask

  // ea must be up in the opcode cycle, one edge after the load
  task automatic run(input logic [95:0] b, input int n, input logic ea,
                     input ctz_pkg::ctz_mode_e m, output int ncyc);
    @(posedge CLK);
    code  <= (b << (96 - 8*n)) | ({12{8'h9D}} >> (8*n));
    start <= 1'b1;
    @(posedge CLK);
    start   <= 1'b0;
    EA_REQ  <= ea;
    EA_MODE <= m;
    @(posedge CLK);
    EA_REQ <= 1'b0;
    #1;
    k = 1;
    // ptr is read after the edge has settled it
    while (ptr !== 8'(n + 1) && k < 60) begin
      @(posedge CLK);
      #1;
      k++;
    end
    ncyc = k - 1;
    @(posedge CLK);
    #1;
  endtask

  task automatic zt_case(input logic [95:0] b, input int n,
                          input logic [7:0] dat, input logic [15:0] adr,
                          input logic [7:0] cc, input int ncyc);
    mdat <= dat;
    run(b, n, 1'b0, ctz_pkg::AM_IMPL, cyc);
    chk(rd_addr, adr);
    chk(16'(cyc), 16'(ncyc));
    chk_regs({16'h6A6A, 8'h01, 16'h0169, cc});
  endtask

  task automatic ea_case(input ctz_pkg::ctz_mode_e m, input logic [95:0] b,
                         input int n, input logic [15:0] adr,
                         input logic [15:0] hx);
    int e0;
    e0 = eas;
    run(b, n, 1'b1, m, cyc);
    chk(EA, adr);
    chk(16'(eas - e0), 16'h0001);
    chk({REGS.h, REGS.x}, hx);
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK);
    #1;
    chk_regs({24'h000000, 16'h00FF, 8'h68});
    // chain ends 12 cycles later, total of per-opcode cycles
    run(72'h8595_9F4D_8584_9794_5D, 9, 1'b0, ctz_pkg::AM_IMPL, cyc);
    chk(16'(cyc), 16'h000C);
    chk_regs({16'h6A6A, 8'h01, 16'h0169, 8'h68});
    chk(16'(FOREIGN), 16'h0001);
    zt_case(16'h3D40, 2, 8'h80, 16'h0040, 8'h6C, 3);
    zt_case(8'h7D, 1, 8'h00, 16'h016A, 8'h6A, 2);
    zt_case(16'h6DF0, 2, 8'h01, 16'h025A, 8'h68, 3);
    zt_case(24'h9E6D10, 3, 8'hFF, 16'h0179, 8'h6C, 4);
    ea_case(ctz_pkg::AM_DIR, 16'h9D40, 2, 16'h0040, 16'h016A);
    ea_case(ctz_pkg::AM_FULL, 24'h9D1234, 3, 16'h1234, 16'h016A);
    ea_case(ctz_pkg::AM_XPLAIN, 8'h9D, 1, 16'h016A, 16'h016A);
    ea_case(ctz_pkg::AM_XSHORT, 16'h9DF0, 2, 16'h025A, 16'h016A);
    ea_case(ctz_pkg::AM_XLONG, 24'h9D0102, 3, 16'h026C, 16'h016A);
    ea_case(ctz_pkg::AM_SSHORT, 16'h9D20, 2, 16'h0189, 16'h016A);
    ea_case(ctz_pkg::AM_SLONG, 24'h9D0100, 3, 16'h0269, 16'h016A);
    ea_case(ctz_pkg::AM_DDREL, 24'h9D40FE, 3, 16'h0040, 16'h016A);
    chk(16'(REL_OFS), 16'h00FE);
    ea_case(ctz_pkg::AM_XPOST, 8'h9D, 1, 16'h016A, 16'h016B);
    ea_case(ctz_pkg::AM_XSHORT_POST, 16'h9D10, 2,
            16'h017B, 16'h016C);
    ea_case(ctz_pkg::AM_IMPL, 8'h9D, 1, 16'h0000, 16'h016C);
    // wait: core stays stopped while no interrupt is pending
    @(posedge CLK);
    code  <= {8'h8F, {11{8'h9D}}};
    start <= 1'b1;
    @(posedge CLK);
    start <= 1'b0;
    repeat (12) @(posedge CLK);
    #1;
    chk(16'(CORE_CLK_EN), 16'h0000);
    chk(16'(ptr), 16'h0001);
    chk(16'(FOREIGN), 16'h0000);
    chk_regs({16'h6A6C, 8'h01, 16'h0169, 8'h64});
    @(posedge CLK);
    IRQ <= 1'b1;
    k = 0;
    while (CORE_CLK_EN !== 1'b1 && k < 6) begin
      @(posedge CLK);
      k++;
    end
    #1;
    chk(16'(CORE_CLK_EN), 16'h0001);
    @(posedge CLK);
    IRQ <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    chk(16'(ptr > 8'h01), 16'h0001);
    report_and_stop();
  end
endmodule

// ---- hw/ctz_decoder.sv ----
// decode and execute of transfer, test-against-zero and wait operations
//
// Overview of operation
// RULE1: test sets N,Z, clears V, others kept
// RULE2: test forms 3D..9E6D take 3,1,1,3,2,4 cycles
// RULE3: wait 8F clears interrupt mask only
// RULE4: wait gates core clock until interrupt
// RULE5: 84 two cycles; 85, 9F, 97 one
// RULE6: 95 gives SP+1, 94 gives HX-1
// RULE7: plain indexed address is HX itself
// RULE8: short indexed adds unsigned byte to HX
// RULE9: long indexed adds high-low offset to HX
// RULE10: short stack mode adds byte to SP
// RULE11: long stack mode adds two bytes to SP
// RULE12: full address mode fetches high then low
// RULE13: direct byte selects first 256 bytes
// RULE14: direct-plus-relative gives address then offset
// RULE15: post-increment plain uses HX then increments
// RULE16: post-increment offset adds byte, increments HX
// RULE17: implied mode fetches no operand bytes
`timescale 1ns/1ps
module ctz_decoder (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // instruction byte stream
  output logic                   FETCH_REQ,
  input  wire logic [7:0]        FETCH_BYTE,
  // operand memory read
  output logic                   MEM_RD,
  output logic [15:0]            MEM_ADDR,
  input  wire logic [7:0]        MEM_RDATA,
  // addressing for opcodes outside this group
  input  wire logic              EA_REQ,
  input  wire ctz_pkg::ctz_mode_e EA_MODE,
  output logic                   EA_VALID,
  output logic [15:0]            EA,
  output logic [7:0]             REL_OFS,
  output logic                   FOREIGN,
  // interrupt and clock gating
  input  wire logic              IRQ,
  output logic                   CORE_CLK_EN,
  // cpu registers
  output ctz_pkg::ctz_regs_s     REGS
);
  // ---------------------------------------------------------------
  // reset release and interrupt synchroniser
  // ---------------------------------------------------------------
  logic rst_m_q, rst_n;
  logic irq_m_q, irq_s_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_m_q <= 1'b0;
      irq_s_q <= 1'b0;
    end else begin
      irq_m_q <= IRQ;
      irq_s_q <= irq_m_q;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] opnd_len(input ctz_pkg::ctz_mode_e m);
    case (m)
      ctz_pkg::AM_DIR, ctz_pkg::AM_XSHORT, ctz_pkg::AM_XSHORT_POST,
      ctz_pkg::AM_SSHORT:               opnd_len = 2'd1;
      ctz_pkg::AM_FULL, ctz_pkg::AM_XLONG, ctz_pkg::AM_SLONG,
      ctz_pkg::AM_DDREL:                opnd_len = 2'd2;
      default:                          opnd_len = 2'd0; // RULE17
    endcase
  endfunction

  // offsets are unsigned; the relative byte is passed on untouched
  function automatic logic [15:0] calc_ea(input ctz_pkg::ctz_mode_e m,
                                          input logic [15:0] ob,
                                          input logic [15:0] hx,
                                          input logic [15:0] sp);
    case (m)
      ctz_pkg::AM_DIR:   calc_ea = {ctz_pkg::PAGE0_HI, ob[7:0]}; // RULE13
      ctz_pkg::AM_DDREL: calc_ea = {ctz_pkg::PAGE0_HI, ob[15:8]}; // RULE14
      ctz_pkg::AM_FULL:  calc_ea = ob; // RULE12
      ctz_pkg::AM_XPLAIN,
      ctz_pkg::AM_XPOST: calc_ea = hx; // RULE7 RULE15
      ctz_pkg::AM_XSHORT,
      ctz_pkg::AM_XSHORT_POST:
        calc_ea = hx + {8'h00, ob[7:0]}; // RULE8 RULE16
      ctz_pkg::AM_XLONG: calc_ea = hx + ob; // RULE9
      ctz_pkg::AM_SSHORT: calc_ea = sp + {8'h00, ob[7:0]}; // RULE10
      ctz_pkg::AM_SLONG: calc_ea = sp + ob; // RULE11
      default:           calc_ea = 16'h0000;
    endcase
  endfunction

  function automatic logic [7:0] zt_flags(input logic [7:0] c,
                                          input logic [7:0] v);
    zt_flags = c;
    zt_flags[ctz_pkg::FLG_V] = 1'b0; // RULE1
    zt_flags[ctz_pkg::FLG_N] = v[7];
    zt_flags[ctz_pkg::FLG_Z] = (v == 8'h00);
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPC, ST_PFX, ST_OPND, ST_READ, ST_EXEC, ST_WAIT
  } ctz_state_e;

  ctz_state_e          st_q, st_d;
  ctz_pkg::ctz_regs_s  r_q, r_d;
  ctz_pkg::ctz_mode_e  mode_q, mode_d;
  logic [1:0]          left_q, left_d;
  logic [15:0]         opnd_q, opnd_d;
  logic [7:0]          op_q, op_d;
  logic                zt_q, zt_d;
  logic                fetch_q, fetch_d, rd_q, rd_d, eav_q, eav_d;
  logic                frn_q, frn_d, clken_q, clken_d;
  logic [15:0]         addr_q, addr_d, ea_q, ea_d;
  logic [7:0]          rel_q, rel_d;
  logic [15:0]         hx, ea_w;

  always_comb begin
    st_d    = st_q;
    r_d     = r_q;
    mode_d  = mode_q;
    left_d  = left_q;
    opnd_d  = opnd_q;
    op_d    = op_q;
    zt_d    = zt_q;
    fetch_d = fetch_q;
    rd_d    = 1'b0;
    addr_d  = addr_q;
    eav_d   = 1'b0;
    ea_d    = ea_q;
    rel_d   = rel_q;
    frn_d   = 1'b0;
    clken_d = clken_q;
    hx      = {r_q.h, r_q.x};
    ea_w    = 16'h0000;
    case (st_q)
      ST_OPC: begin
        op_d  = FETCH_BYTE;
        zt_d  = 1'b1;
        case (FETCH_BYTE)
          ctz_pkg::OP_ZT_ACC:
            r_d.flags = zt_flags(r_q.flags, r_q.a); // RULE2
          ctz_pkg::OP_ZT_IDX:
            r_d.flags = zt_flags(r_q.flags, r_q.x); // RULE2
          ctz_pkg::OP_ACC_TO_IDX: r_d.x = r_q.a; // RULE5
          ctz_pkg::OP_FLG_TO_ACC: r_d.a = r_q.flags; // RULE5
          ctz_pkg::OP_IDX_TO_ACC: r_d.a = r_q.x; // RULE5
          ctz_pkg::OP_TAP, ctz_pkg::OP_STK_TO_IDX,
          ctz_pkg::OP_IDX_TO_STK: begin
            fetch_d = 1'b0; // RULE5 RULE6
            st_d    = ST_EXEC;
          end
          ctz_pkg::OP_WAIT: begin
            r_d.flags[ctz_pkg::FLG_I] = 1'b0; // RULE3
            fetch_d = 1'b0;
            clken_d = 1'b0; // RULE4
            st_d    = ST_WAIT;
          end
          ctz_pkg::OP_ZT_DIR: begin
            mode_d = ctz_pkg::AM_DIR; // RULE2
            left_d = 2'd1;
            st_d   = ST_OPND;
          end
          ctz_pkg::OP_ZT_SHORT: begin
            mode_d = ctz_pkg::AM_XSHORT; // RULE2
            left_d = 2'd1;
            st_d   = ST_OPND;
          end
          ctz_pkg::OP_ZT_PLAIN: begin
            fetch_d = 1'b0; // RULE2
            rd_d    = 1'b1;
            addr_d  = calc_ea(ctz_pkg::AM_XPLAIN, 16'h0000, hx, r_q.sp);
            st_d    = ST_READ;
          end
          ctz_pkg::OP_PREFIX: st_d = ST_PFX;
          default: begin
            frn_d = 1'b1;
            zt_d  = 1'b0;
            if (EA_REQ) begin
              mode_d = EA_MODE;
              left_d = opnd_len(EA_MODE);
              if (opnd_len(EA_MODE) == 2'd0) begin
                eav_d = 1'b1; // RULE17
                ea_d  = calc_ea(EA_MODE, 16'h0000, hx, r_q.sp);
                if (EA_MODE == ctz_pkg::AM_XPOST)
                  {r_d.h, r_d.x} = hx + 16'h0001; // RULE15
              end else begin
                st_d = ST_OPND;
              end
            end
          end
        endcase
      end
      ST_PFX: begin
        if (FETCH_BYTE == ctz_pkg::OP_ZT_STK) begin
          mode_d = ctz_pkg::AM_SSHORT; // RULE2
          left_d = 2'd1;
          st_d   = ST_OPND;
        end else begin
          frn_d = 1'b1;
          st_d  = ST_OPC;
        end
      end
      ST_OPND: begin
        opnd_d = {opnd_q[7:0], FETCH_BYTE}; // high byte arrives first
        left_d = left_q - 2'd1;
        if (left_q == 2'd1) begin
          ea_w = calc_ea(mode_q, opnd_d, hx, r_q.sp);
          if (mode_q == ctz_pkg::AM_XSHORT_POST)
            {r_d.h, r_d.x} = hx + 16'h0001; // RULE16
          if (zt_q) begin
            rd_d    = 1'b1;
            addr_d  = ea_w;
            fetch_d = 1'b0;
            st_d    = ST_READ;
          end else begin
            eav_d = 1'b1;
            ea_d  = ea_w;
            rel_d = opnd_d[7:0]; // RULE14
            st_d  = ST_OPC;
          end
        end
      end
      ST_READ: begin
        r_d.flags = zt_flags(r_q.flags, MEM_RDATA); // RULE1
        fetch_d = 1'b1;
        st_d    = ST_OPC;
      end
      ST_EXEC: begin
        case (op_q)
          ctz_pkg::OP_TAP:
            r_d.flags = r_q.a | ctz_pkg::FLG_FIXED; // RULE5
          ctz_pkg::OP_STK_TO_IDX:
            {r_d.h, r_d.x} = r_q.sp + 16'h0001; // RULE6
          default:         r_d.sp = hx - 16'h0001; // RULE6
        endcase
        fetch_d = 1'b1;
        st_d    = ST_OPC;
      end
      ST_WAIT: begin
        if (irq_s_q) begin
          clken_d = 1'b1; // RULE4
          fetch_d = 1'b1;
          st_d    = ST_OPC;
        end
      end
      default: st_d = ST_OPC;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_OPC;
      r_q     <= '{8'h00, 8'h00, 8'h00, ctz_pkg::SP_RESET,
                   ctz_pkg::FLG_RESET};
      mode_q  <= ctz_pkg::AM_IMPL;
      left_q  <= 2'd0;
      opnd_q  <= 16'h0000;
      op_q    <= 8'h00;
      zt_q    <= 1'b0;
      fetch_q <= 1'b1;
      rd_q    <= 1'b0;
      addr_q  <= 16'h0000;
      eav_q   <= 1'b0;
      ea_q    <= 16'h0000;
      rel_q   <= 8'h00;
      frn_q   <= 1'b0;
      clken_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      r_q     <= r_d;
      mode_q  <= mode_d;
      left_q  <= left_d;
      opnd_q  <= opnd_d;
      op_q    <= op_d;
      zt_q    <= zt_d;
      fetch_q <= fetch_d;
      rd_q    <= rd_d;
      addr_q  <= addr_d;
      eav_q   <= eav_d;
      ea_q    <= ea_d;
      rel_q   <= rel_d;
      frn_q   <= frn_d;
      clken_q <= clken_d;
    end
  end

  assign FETCH_REQ   = fetch_q;
  assign MEM_RD      = rd_q;
  assign MEM_ADDR    = addr_q;
  assign EA_VALID    = eav_q;
  assign EA          = ea_q;
  assign REL_OFS     = rel_q;
  assign FOREIGN     = frn_q;
  assign CORE_CLK_EN = clken_q;
  assign REGS        = r_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_zt_mem_flags: assert property ( // RULE1
    st_q == ST_READ |=> !REGS.flags[ctz_pkg::FLG_V] &&
      REGS.flags[ctz_pkg::FLG_Z] == ($past(MEM_RDATA) == 8'h00))
    else $error("memory test flags wrong");
  a_zt_plain_two: assert property ( // RULE2
    st_q == ST_OPC && FETCH_BYTE == ctz_pkg::OP_ZT_PLAIN |=>
      MEM_RD && !FETCH_REQ && MEM_ADDR == $past({REGS.h, REGS.x})
      ##1 FETCH_REQ && !MEM_RD)
    else $error("plain indexed test timing wrong");
  a_wait_entry: assert property ( // RULE3
    st_q == ST_OPC && FETCH_BYTE == ctz_pkg::OP_WAIT |=>
      !CORE_CLK_EN && !REGS.flags[ctz_pkg::FLG_I] &&
      REGS.flags[7:4] == $past(REGS.flags[7:4]))
    else $error("wait entry wrong");
  a_wait_hold: assert property ( // RULE4
    !CORE_CLK_EN && !irq_s_q |=> !CORE_CLK_EN && !FETCH_REQ)
    else $error("core clock resumed without interrupt");
  a_tap_two: assert property ( // RULE5
    st_q == ST_OPC && FETCH_BYTE == ctz_pkg::OP_TAP |=> !FETCH_REQ
      ##1 FETCH_REQ &&
      REGS.flags == ($past(REGS.a, 2) | ctz_pkg::FLG_FIXED))
    else $error("flags load wrong");
  a_acc_idx_one: assert property ( // RULE5
    st_q == ST_OPC && FETCH_BYTE == ctz_pkg::OP_ACC_TO_IDX |=>
      FETCH_REQ && REGS.x == $past(REGS.a))
    else $error("acc to index move wrong");
  a_stk_idx_value: assert property ( // RULE6
    st_q == ST_OPC && FETCH_BYTE == ctz_pkg::OP_STK_TO_IDX |-> ##2
      {REGS.h, REGS.x} == 16'($past(REGS.sp, 2) + 16'h0001))
    else $error("stack to index wrong");
  a_idx_stk_value: assert property ( // RULE6
    st_q == ST_OPC && FETCH_BYTE == ctz_pkg::OP_IDX_TO_STK |-> ##2
      REGS.sp == 16'($past({REGS.h, REGS.x}, 2) - 16'h0001))
    else $error("index to stack wrong");
  a_dir_addr: assert property ( // RULE13
    st_q == ST_OPND && left_q == 2'd1 && zt_q &&
      mode_q == ctz_pkg::AM_DIR |=>
      MEM_RD && MEM_ADDR == {ctz_pkg::PAGE0_HI, $past(FETCH_BYTE)})
    else $error("direct address wrong");
  a_impl_nofetch: assert property ( // RULE17
    st_q == ST_OPC && EA_REQ && EA_MODE == ctz_pkg::AM_IMPL |=>
      EA_VALID == FOREIGN)
    else $error("implied mode did not finish at once");
endmodule

// ---- hw/ctz_pkg.sv ----
// shared constants and types for the transfer, test and wait decoder
package ctz_pkg;
  // ---------------------------------------------------------------
  // opcodes handled by this group
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_TAP     = 8'h84;
  localparam logic [7:0] OP_FLG_TO_ACC = 8'h85;
  localparam logic [7:0] OP_ACC_TO_IDX = 8'h97;
  localparam logic [7:0] OP_IDX_TO_ACC = 8'h9F;
  localparam logic [7:0] OP_STK_TO_IDX = 8'h95;
  localparam logic [7:0] OP_IDX_TO_STK = 8'h94;
  localparam logic [7:0] OP_WAIT    = 8'h8F;
  localparam logic [7:0] OP_ZT_DIR   = 8'h3D;
  localparam logic [7:0] OP_ZT_ACC   = 8'h4D;
  localparam logic [7:0] OP_ZT_IDX   = 8'h5D;
  localparam logic [7:0] OP_ZT_SHORT = 8'h6D;
  localparam logic [7:0] OP_ZT_PLAIN = 8'h7D;
  localparam logic [7:0] OP_PREFIX  = 8'h9E;
  localparam logic [7:0] OP_ZT_STK   = 8'h6D;
  // ---------------------------------------------------------------
  // flag positions and reset values
  // ---------------------------------------------------------------
  localparam int         FLG_V      = 7;
  localparam int         FLG_I      = 3;
  localparam int         FLG_N      = 2;
  localparam int         FLG_Z      = 1;
  localparam logic [7:0] FLG_FIXED  = 8'h60;
  localparam logic [7:0] FLG_RESET  = 8'h68;
  localparam logic [15:0] SP_RESET  = 16'h00FF;
  localparam logic [7:0] PAGE0_HI   = 8'h00;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    AM_IMPL, AM_DIR, AM_FULL, AM_XPLAIN, AM_XSHORT, AM_XLONG,
    AM_XPOST, AM_XSHORT_POST, AM_SSHORT, AM_SLONG, AM_DDREL
  } ctz_mode_e;
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  x;
    logic [7:0]  h;
    logic [15:0] sp;
    logic [7:0]  flags;
  } ctz_regs_s;
endpackage
